// File: logic/dma_engine.sv
// multi-channel dma engine with axi4-lite registers and a system bus port
// assumes one clock, peripherals keep to the request/acknowledge handshake
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module dma_engine
  import dma_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [N-1:0]        periph_req,
  output logic      [N-1:0]        periph_ack,
  output sys_req_s                 sys_req,
  input  wire logic                sys_ready,
  input  wire logic [DATA_W-1:0]   sys_rdata,
  output logic      [N-1:0]        chan_irq
);

  localparam int CW = $clog2(N);

  chan_ctrl_s        ctrl_q   [N];
  logic [ADDR_W-1:0] pbase_q  [N];
  logic [ADDR_W-1:0] mbase_q  [N];
  logic [ADDR_W-1:0] pcur_q   [N];
  logic [ADDR_W-1:0] mcur_q   [N];
  logic [CNT_W-1:0]  prog_q   [N];
  logic [CNT_W-1:0]  rem_q    [N];
  logic [N-1:0]      half_q;
  logic [N-1:0]      done_q;

  eng_state_e        st_q;
  logic [CW-1:0]     ch_q;
  logic [DATA_W-1:0] data_q;

  // axi4-lite write side
  logic              aw_held_q;
  logic              w_held_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_fire;
  logic              wr_hit;
  logic [CW-1:0]     wr_ch;
  logic [3:0]        wr_off;
  logic [31:0]       wr_mask;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_ch   = awaddr_q[4 +: CW];
  assign wr_off  = awaddr_q[3:0];
  assign wr_hit  = (awaddr_q < CH_STRIDE * N[7:0]) && (wr_off[1:0] == 2'b00);

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_mask[8*b +: 8] = {8{wstrb_q[b]}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_hit || awaddr_q == OFF_FLAG_CLR) ? RESP_OKAY
                                                          : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // axi4-lite read side, one cycle from address to data
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [CW-1:0] rd_ch;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_ch         = s_axi_araddr[4 +: CW];

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr < CH_STRIDE * N[7:0]) begin
      unique case (s_axi_araddr[3:0])
        OFF_CTRL:  rd_word = {16'h0000, ctrl_q[rd_ch]};
        OFF_PBASE: rd_word = pbase_q[rd_ch];
        OFF_MBASE: rd_word = mbase_q[rd_ch];
        OFF_COUNT: rd_word = {16'h0000, rem_q[rd_ch]};
        default:   rd_hit  = 1'b0;
      endcase
    end else if (s_axi_araddr == OFF_FLAGS) begin
      rd_word = {16'h0000, half_q, done_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // arbitration
  logic [N-1:0]   pending;
  logic [2*N-1:0] levels;
  logic           gnt_valid;
  logic [CW-1:0]  gnt_idx;

  for (genvar i = 0; i < N; i++) begin : g_pend
    assign pending[i] = ctrl_q[i].enable && (rem_q[i] != '0)
                     && (periph_req[i]
                     || ctrl_q[i].memory_copy_mode
                     || ctrl_q[i].sw_trigger);
    assign levels[2*i +: 2] = ctrl_q[i].priority_level;
    assign chan_irq[i] = (half_q[i] && ctrl_q[i].half_done_irq_on)
                      || (done_q[i] && ctrl_q[i].all_done_irq_on);
  end

  dma_arbiter #(.N(N)) u_arb (
    .pending     (pending),
    .levels      (levels),
    .grant_valid (gnt_valid),
    .grant_idx   (gnt_idx)
  );

  // current channel view
  chan_ctrl_s        cc;
  logic [ADDR_W-1:0] pnext;
  logic [ADDR_W-1:0] mnext;
  logic [CNT_W-1:0]  rem_dec;
  logic              xfer_done;
  logic [1:0]        src_size;

  assign cc        = ctrl_q[ch_q];
  assign rem_dec   = rem_q[ch_q] - 16'h0001;
  assign xfer_done = (st_q == ST_WRITE) && sys_ready;
  assign src_size  = cc.to_periph ? cc.mem_elem_width : cc.periph_elem_width;

  dma_addr_step u_pstep (
    .cur     (pcur_q[ch_q]),
    .step_on (cc.periph_addr_step_on),
    .size    (cc.periph_elem_width),
    .next    (pnext)
  );

  dma_addr_step u_mstep (
    .cur     (mcur_q[ch_q]),
    .step_on (cc.mem_addr_step_on),
    .size    (cc.mem_elem_width),
    .next    (mnext)
  );

  // system bus request, read from the source then write to the destination
  always_comb begin
    sys_req       = '0;
    sys_req.valid = (st_q == ST_READ) || (st_q == ST_WRITE);
    sys_req.write = (st_q == ST_WRITE);
    sys_req.wdata = data_q;
    if ((st_q == ST_READ) == cc.to_periph) begin
      sys_req.addr = mcur_q[ch_q];
      sys_req.size = cc.mem_elem_width;
    end else begin
      sys_req.addr = pcur_q[ch_q];
      sys_req.size = cc.periph_elem_width;
    end
  end

  // peripheral acknowledge stands from the access until request drops
  always_comb begin
    periph_ack = '0;
    if (st_q == ST_ACK) begin
      periph_ack[ch_q] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= ST_IDLE;
      ch_q   <= '0;
      data_q <= 32'h0000_0000;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (gnt_valid) begin
            ch_q <= gnt_idx;
            st_q <= ST_READ;
          end
        end
        ST_READ: begin
          if (sys_ready) begin
            // no packing: narrower source is zero extended
            unique case (src_size)
              SZ_BYTE: data_q <= {24'h000000, sys_rdata[7:0]};
              SZ_HALF: data_q <= {16'h0000, sys_rdata[15:0]};
              default: data_q <= sys_rdata;
            endcase
            st_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (sys_ready) begin
            // soft and copy transfers have no peripheral to answer
            st_q <= (periph_req[ch_q] && !cc.memory_copy_mode
                     && !cc.sw_trigger) ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (!periph_req[ch_q]) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // channel registers, current addresses, counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N; i++) begin
        ctrl_q[i]  <= CTRL_RESET;
        pbase_q[i] <= '0;
        mbase_q[i] <= '0;
        pcur_q[i]  <= '0;
        mcur_q[i]  <= '0;
        prog_q[i]  <= '0;
        rem_q[i]   <= '0;
      end
    end else begin
      if (xfer_done) begin
        if (rem_dec == '0 && cc.wrap_reload_mode) begin
          rem_q[ch_q]  <= prog_q[ch_q];
          pcur_q[ch_q] <= pbase_q[ch_q];
          mcur_q[ch_q] <= mbase_q[ch_q];
        end else begin
          rem_q[ch_q]  <= rem_dec;
          pcur_q[ch_q] <= pnext;
          mcur_q[ch_q] <= mnext;
        end
        ctrl_q[ch_q].sw_trigger <= 1'b0;
      end
      // a software write lands after the engine update, so it wins
      if (wr_fire && wr_hit) begin
        unique case (wr_off)
          OFF_CTRL: begin
            ctrl_q[wr_ch] <= (ctrl_q[wr_ch] & ~wr_mask[15:0])
                           | (wdata_q[15:0] & wr_mask[15:0]);
            if (!ctrl_q[wr_ch].enable && wdata_q[0] && wstrb_q[0]) begin
              pcur_q[wr_ch] <= pbase_q[wr_ch];
              mcur_q[wr_ch] <= mbase_q[wr_ch];
            end
          end
          OFF_PBASE: pbase_q[wr_ch] <= (pbase_q[wr_ch] & ~wr_mask)
                                     | (wdata_q & wr_mask);
          OFF_MBASE: mbase_q[wr_ch] <= (mbase_q[wr_ch] & ~wr_mask)
                                     | (wdata_q & wr_mask);
          OFF_COUNT: begin
            if (!ctrl_q[wr_ch].enable) begin
              prog_q[wr_ch] <= wdata_q[CNT_W-1:0];
              rem_q[wr_ch]  <= wdata_q[CNT_W-1:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // event flags, a hardware set beats a same-cycle software clear
  logic [N-1:0] clr;
  logic [N-1:0] set_half;
  logic [N-1:0] set_done;

  always_comb begin
    clr      = '0;
    set_half = '0;
    set_done = '0;
    if (wr_fire && awaddr_q == OFF_FLAG_CLR) begin
      clr = wdata_q[N-1:0] | wdata_q[N +: N];
    end
    if (xfer_done) begin
      set_half[ch_q] = (rem_dec == (prog_q[ch_q] >> 1));
      set_done[ch_q] = (rem_dec == '0);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q <= '0;
      done_q <= '0;
    end else begin
      half_q <= (half_q & ~clr) | set_half;
      done_q <= (done_q & ~clr) | set_done;
    end
  end

endmodule
`default_nettype wire

// File: logic/dma_pkg.sv
// shared constants and carriers for the multi-channel dma engine
// assumes a 32-bit axi4-lite register bus and a 32-bit system bus port
package dma_pkg;

  localparam int NUM_CH    = 8;
  localparam int CNT_W     = 16;
  localparam int ADDR_W    = 32;
  localparam int DATA_W    = 32;

  // per channel register block, stride 16 bytes
  localparam logic [7:0] CH_STRIDE     = 8'h10;
  localparam logic [3:0] OFF_CTRL      = 4'h0;
  localparam logic [3:0] OFF_PBASE     = 4'h4;
  localparam logic [3:0] OFF_MBASE     = 4'h8;
  localparam logic [3:0] OFF_COUNT     = 4'hc;
  localparam logic [7:0] OFF_FLAGS     = 8'h80;
  localparam logic [7:0] OFF_FLAG_CLR  = 8'h84;

  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // element widths: byte, half word, word
  localparam logic [1:0] SZ_BYTE = 2'b00;
  localparam logic [1:0] SZ_HALF = 2'b01;
  localparam logic [1:0] SZ_WORD = 2'b10;

  typedef struct packed {
    logic       sw_trigger;
    logic       memory_copy_mode;
    logic [1:0] priority_level;     // 11 very high .. 00 low
    logic [1:0] mem_elem_width;
    logic [1:0] periph_elem_width;
    logic       mem_addr_step_on;
    logic       periph_addr_step_on;
    logic       wrap_reload_mode;
    logic       to_periph;          // 1: memory to peripheral
    logic       unused3;
    logic       half_done_irq_on;
    logic       all_done_irq_on;
    logic       enable;
  } chan_ctrl_s;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [1:0]        size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sys_req_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_ACK   = 2'b11
  } eng_state_e;

endpackage

// File: logic/dma_arbiter.sv
// two-stage channel arbiter: software level first, then lower index
// assumes pending and levels are stable while the engine samples them
`timescale 1ns/10ps
`default_nettype none
module dma_arbiter
  import dma_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input  wire logic [N-1:0]     pending,
  input  wire logic [2*N-1:0]   levels,
  output logic                  grant_valid,
  output logic [$clog2(N)-1:0]  grant_idx
);

  always_comb begin
    logic [1:0] best;
    best        = 2'b00;
    grant_valid = 1'b0;
    grant_idx   = '0;
    // walking downward with >= lets the lower index win a tie
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i] && (!grant_valid || levels[2*i +: 2] >= best)) begin
        grant_valid = 1'b1;
        grant_idx   = i[$clog2(N)-1:0];
        best        = levels[2*i +: 2];
      end
    end
  end

endmodule
`default_nettype wire

// File: logic/dma_addr_step.sv
// next address of one side: post-increment by the element width
// assumes size codes byte, half word or word only
`timescale 1ns/10ps
`default_nettype none
module dma_addr_step
  import dma_pkg::*;
(
  input  wire logic [ADDR_W-1:0] cur,
  input  wire logic              step_on,
  input  wire logic [1:0]        size,
  output logic      [ADDR_W-1:0] next
);

  logic [ADDR_W-1:0] inc;

  always_comb begin
    unique case (size)
      SZ_BYTE: inc = 32'h0000_0001;
      SZ_HALF: inc = 32'h0000_0002;
      SZ_WORD: inc = 32'h0000_0004;
      default: inc = 32'h0000_0004;
    endcase
    next = step_on ? cur + inc : cur;
  end

endmodule
`default_nettype wire

// File: verif/dma_engine_asserts.sv
// port assertions for the dma engine, bound onto dma_engine
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module dma_engine_chk
  import dma_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic         s_axi_rvalid,
  input wire logic [N-1:0] periph_req,
  input wire logic [N-1:0] periph_ack,
  input wire sys_req_s     sys_req,
  input wire logic         sys_ready
);
  logic wr_done_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_done;
    sys_req.valid && !sys_req.write && sys_ready;
  endsequence
  sequence wr_start;
    sys_req.valid && sys_req.write;
  endsequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_done_q <= 1'b0;
    end else begin
      wr_done_q <= sys_req.valid && sys_req.write && sys_ready;
    end
  end
  ack_hold_a: assert property (
    |(periph_ack & periph_req) |=> $stable(periph_ack))
    else $error("ack changed while request high");
  ack_drop_a: assert property (
    periph_ack != '0 && !(|(periph_ack & periph_req)) |=> periph_ack == '0)
    else $error("ack kept after request fell");
  ack_onehot_a: assert property ($onehot0(periph_ack))
    else $error("ack to several channels");
  ack_cause_a: assert property (
    $rose(|periph_ack) |-> wr_done_q)
    else $error("ack without a finished access");
  read_then_write_a: assert property (rd_done |=> wr_start)
    else $error("read not followed by write");
  req_hold_a: assert property (
    sys_req.valid && !sys_ready |=> $stable(sys_req))
    else $error("bus request changed while stalled");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
endmodule
bind dma_engine dma_engine_chk #(.N(N)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .periph_req(periph_req),
  .periph_ack(periph_ack), .sys_req(sys_req), .sys_ready(sys_ready));
`default_nettype wire

// File: verif/dma_far_model.sv
// peripherals and system memory seen by the dma engine
// assumes trig pulses come from the bench; stall sets bus wait states
`timescale 1ns/10ps
`default_nettype none
module dma_far_model
  import dma_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [N-1:0]      trig,
  input  wire logic [1:0]        stall,
  input  wire logic [N-1:0]      periph_ack,
  output logic      [N-1:0]      periph_req,
  input  wire sys_req_s          sys_req,
  output logic                   sys_ready,
  output logic      [DATA_W-1:0] sys_rdata
);
  logic [N-1:0]      want_q;
  logic [1:0]        wait_q;
  logic [DATA_W-1:0] noise_q;
  logic [ADDR_W-1:0] wa[$];
  logic [ADDR_W-1:0] ra[$];
  logic [DATA_W-1:0] wd[$];
  logic [1:0]        wsz[$];
  logic [1:0]        rsz[$];
  assign sys_ready = sys_req.valid && (wait_q == stall);
  // outside a read the data lines wander so stale data is never trusted
  assign sys_rdata = (sys_ready && !sys_req.write) ? ~sys_req.addr : noise_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      periph_req <= '0;
      want_q <= '0;
      wait_q <= '0;
      noise_q <= 32'h0000_0000;
    end else begin
      noise_q <= noise_q + 32'h0101_0101;
      for (int i = 0; i < N; i++) begin
        if (trig[i]) want_q[i] <= 1'b1;
        if (periph_ack[i]) begin
          periph_req[i] <= 1'b0;
        end else if (want_q[i] && !periph_req[i]) begin
          periph_req[i] <= 1'b1;
          want_q[i] <= 1'b0;
        end
      end
      if (sys_req.valid && !sys_ready) wait_q <= wait_q + 2'h1;
      else wait_q <= '0;
      if (sys_ready && sys_req.write) begin
        wa.push_back(sys_req.addr);
        wd.push_back(sys_req.wdata);
        wsz.push_back(sys_req.size);
      end else if (sys_ready) begin
        ra.push_back(sys_req.addr);
        rsz.push_back(sys_req.size);
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/test_dma_engine.sv
// self-checking bench: axi4-lite register calls and dma traffic checks
// assumes dma_far_model for the far side and the bound port checker
`timescale 1ns/10ps
`default_nettype none
module test_dma_engine
  import dma_pkg::*;
;
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]        awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata, srdata, d;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic              rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, r, stall = '0;
  logic [3:0]        wstrb = 4'hf;
  logic [NUM_CH-1:0] req, ack, irq, trig = '0;
  sys_req_s          sreq;
  logic              sready;
  int                n_fail = 0, samples_checked = 0;
  always #12.5 aclk = ~aclk;
  dma_engine #(.N(NUM_CH)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .periph_req(req), .periph_ack(ack),
    .sys_req(sreq), .sys_ready(sready), .sys_rdata(srdata), .chan_irq(irq));
  dma_far_model #(.N(NUM_CH)) far (
    .aclk(aclk), .aresetn(aresetn), .trig(trig), .stall(stall),
    .periph_ack(ack), .periph_req(req), .sys_req(sreq), .sys_ready(sready),
    .sys_rdata(srdata));
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        return;
      end
    end
    chk(32'h1, 32'h0);
    give_verdict();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        return;
      end
    end
    chk(32'h1, 32'h0);
    give_verdict();
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, r);
    chk(r, RESP_OKAY);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    chk(d, exp);
  endtask
  // programming order: addresses, count, then control with enable
  task automatic cfg(input logic [3:0] ch, input logic [31:0] pb, mb, n, c);
    wreg({ch, OFF_PBASE}, pb);
    wreg({ch, OFF_MBASE}, mb);
    wreg({ch, OFF_COUNT}, n);
    wreg({ch, OFF_CTRL}, c);
  endtask
  task automatic pulse(input logic [NUM_CH-1:0] m);
    @(posedge aclk);
    trig <= m;
    @(posedge aclk);
    trig <= '0;
  endtask
  task automatic wait_wr(input int n);
    for (int i = 0; i < 400; i++) begin
      if (far.wa.size() >= n) return;
      @(posedge aclk);
    end
    chk(32'h1, 32'h0);
    give_verdict();
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h00, 32'h0);
    rd(8'h90, d, r);
    chk(r, RESP_SLVERR);
    wr(8'h88, 32'h1, r);
    chk(r, RESP_SLVERR);
    stall <= 2'h1;
    cfg(4'h1, 32'h40, 32'h1000, 32'h4, 32'h0a87);
    for (int k = 0; k < 4; k++) begin
      pulse(8'h02);
      wait_wr(k + 1);
      chk(far.wa[k], 32'h1000 + 4 * k);
      chk(far.wd[k], ~32'h40);
      chk(far.ra[k], 32'h40);
      if (k == 1) rchk(OFF_FLAGS, 32'h0200);
    end
    rchk(OFF_FLAGS, 32'h0202);
    chk(irq, 32'h02);
    rchk(8'h1c, 32'h0);
    rchk(8'h14, 32'h40);
    wreg(8'h1c, 32'h7);
    rchk(8'h1c, 32'h0);
    pulse(8'h02);
    repeat (20) @(posedge aclk);
    chk(far.wa.size(), 32'h4);
    wreg(8'h10, 32'h0a86);
    rchk(8'h18, 32'h1000);
    rchk(8'h10, 32'h0a86);
    wreg(OFF_FLAG_CLR, 32'h0202);
    chk(irq, 32'h0);
    wreg(8'h1c, 32'h1);
    rchk(8'h1c, 32'h1);
    chk(far.wa.size(), 32'h4);
    wreg(8'h10, 32'h0a87);
    wait_wr(5);
    chk(far.wa[4], 32'h1000);
    // only byte lane 1 of the word may land
    wstrb <= 4'h2;
    wreg(8'h34, 32'h1234_5678);
    wstrb <= 4'hf;
    rchk(8'h34, 32'h0000_5600);
    stall <= 2'h2;
    cfg(4'h2, 32'h20, 32'h2000, 32'h1, 32'h1a01);
    cfg(4'h4, 32'h24, 32'h4000, 32'h1, 32'h1a01);
    cfg(4'h3, 32'h30, 32'h3000, 32'h1, 32'h2a01);
    cfg(4'h5, 32'h34, 32'h5000, 32'h1, 32'h3a01);
    pulse(8'h3c);
    wait_wr(9);
    chk(far.wa[5], 32'h5000);
    chk(far.wa[6], 32'h3000);
    chk(far.wa[7], 32'h2000);
    chk(far.wa[8], 32'h4000);
    stall <= 2'h0;
    cfg(4'h0, 32'h100, 32'h6000, 32'h2, 32'h45c1);
    wait_wr(11);
    chk(far.wa[10], 32'h6002);
    chk(far.ra[10], 32'h102);
    chk(far.wd[10], 32'h0000_fefd);
    chk(far.wsz[10], SZ_HALF);
    cfg(4'h7, 32'h200, 32'h7000, 32'h2, 32'h40c1);
    wait_wr(13);
    chk(far.wa[12], 32'h7001);
    chk(far.wd[12], 32'h0000_00fe);
    repeat (20) @(posedge aclk);
    chk(far.wa.size(), 32'hd);
    wreg(8'h70, 32'h0);
    // soft trigger, memory to peripheral, word read and half word write
    cfg(4'h7, 32'h200, 32'h7100, 32'h1, 32'h8911);
    wait_wr(14);
    chk(far.ra[13], 32'h7100);
    chk(far.wa[13], 32'h200);
    chk(far.wd[13], 32'hffff_8eff);
    chk(far.rsz[13], SZ_WORD);
    chk(far.wsz[13], SZ_HALF);
    rchk(8'h70, 32'h0911);
    cfg(4'h6, 32'h60, 32'h8000, 32'h2, 32'h0aa1);
    for (int k = 0; k < 3; k++) begin
      pulse(8'h40);
      wait_wr(15 + k);
    end
    chk(far.wa[15], 32'h8004);
    chk(far.wa[16], 32'h8000);
    rchk(8'h6c, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
